// ---- design/perm_fail_and_lifetime_log.sv ----
// Permanent failure recording, fuse latch, display and lifetime extremes
//
// The address-and-strobe port and the register offsets were chosen for this implementation.
`timescale 1ns/100ps

// Operation
// - Display mode: 01 needs button hold, 11 automatic
// - Serial LED selection blanks failure display
// - Recovery word holds per-fault current recovery enables
// - Low flags: input, overvoltage, charge/discharge overtemp
// - Low flags: imbalance, switch fails, flash fault
// - High flags: frontend comms, overcurrents, open thermistor
// - Fuse-blow-fail when current flows after fuse
// - Enable bit per flag 0 to 11 gates fuse outputs; open thermistor has none
// - Flag and enable latch fuse low, complement high
// - Fuse-blow-fail never trips the fuse
// - Temperature extremes: 60 s persistence or 1.0 C
// - Cell voltage extremes: 60 s or 25 mV
// - Pack voltage extremes: 60 s or 100 mV
// - Charge/discharge current maxima by sign, 100 mA
// - Charge/discharge power maxima: 60 s or 1000 mW
// - Average temperature stored on 1 C departure
// - Average is plain mean over sample counter
// - Any trigger writes the whole lifetime set
// - No lifetime writes before tracking enabled
// - Fixed pack bit selects alternative recovery
module perm_fail_and_lifetime_log #(
  parameter logic [31:0] PERSIST_CYCLES =
    32'(perm_fail_pkg::PERSIST_CYCLES_CALC),
  parameter logic [31:0] HOLD_CYCLES = 32'(perm_fail_pkg::HOLD_CYCLES_CALC)
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire perm_fail_pkg::reg_req_type i_reg,
  output logic [15:0] o_rdata,
  input wire logic [15:0] i_fail_event,
  input wire logic i_current_flowing,
  input wire perm_fail_pkg::meas_type i_meas,
  input wire logic i_tracking_enable_flag,
  input wire logic i_display_button_n,
  input wire logic i_soc_display_done,
  output logic o_fail_display_start,
  output logic o_fuse_n,
  output logic o_fuse,
  output logic [15:0] o_recovery_select,
  output logic o_nv_write
);

  localparam int NCH = perm_fail_pkg::NCH;

  if (PERSIST_CYCLES == 32'h0000_0000) begin : g_bad_persist
    $error("PERSIST_CYCLES must be at least one");
  end
  if (HOLD_CYCLES == 32'h0000_0000) begin : g_bad_hold
    $error("HOLD_CYCLES must be at least one");
  end

  perm_fail_pkg::state_type st_q;
  perm_fail_pkg::state_type st_d;

  logic [NCH-1:0][17:0] meas_x;
  logic [NCH-1:0][17:0] life_x;
  logic [NCH-1:0] beyond;
  logic [NCH-1:0] step_hit;
  logic [NCH-1:0] persist_hit;
  logic signed [17:0] temp_x;
  logic signed [17:0] cur_x;
  logic signed [17:0] pwr_x;
  logic signed [47:0] avg_full;
  logic signed [17:0] avg_now;
  logic signed [17:0] avg_diff;
  logic avg_hit;
  logic commit;
  logic trip;
  logic [15:0] out_en_bits;

  // Measured value per channel, widened to a common signed form
  always_comb begin
    temp_x = 18'(signed'(i_meas.temp));
    cur_x = 18'(signed'(i_meas.avg_current));
    pwr_x = 18'(signed'(i_meas.avg_power));
    meas_x[0] = temp_x;
    meas_x[1] = temp_x;
    meas_x[2] = {2'h0, i_meas.cell_max};
    meas_x[3] = {2'h0, i_meas.cell_min};
    meas_x[4] = {2'h0, i_meas.pack};
    meas_x[5] = {2'h0, i_meas.pack};
    meas_x[6] = (cur_x > 18'sh00000) ? cur_x : 18'h00000;
    meas_x[7] = (cur_x < 18'sh00000) ? 18'(-cur_x) : 18'h00000;
    // sign selects charge or discharge power
    meas_x[8] = (pwr_x > 18'sh00000) ? pwr_x : 18'h00000;
    meas_x[9] = (pwr_x < 18'sh00000) ? 18'(-pwr_x) : 18'h00000;
  end

  always_comb begin
    for (int i = 0; i < NCH; i++) begin
      life_x[i] = perm_fail_pkg::CH_SIGNED[i] ?
        18'(signed'(st_q.life[i])) : {2'h0, st_q.life[i]};
      if (perm_fail_pkg::CH_IS_MIN[i]) begin
        beyond[i] = $signed(life_x[i]) > $signed(meas_x[i]);
        step_hit[i] = $signed(life_x[i]) - $signed(meas_x[i]) >
          $signed({2'h0, perm_fail_pkg::LIFE_STEP[i]});
      end else begin
        beyond[i] = $signed(meas_x[i]) > $signed(life_x[i]);
        step_hit[i] = $signed(meas_x[i]) - $signed(life_x[i]) >
          $signed({2'h0, perm_fail_pkg::LIFE_STEP[i]});
      end
      persist_hit[i] = beyond[i] && (st_q.timer[i] == PERSIST_CYCLES);
    end
  end

  // plain mean of all samples taken
  always_comb begin
    avg_full = (st_q.samples == 32'h0000_0000) ? 48'sh0 :
      $signed(st_q.temp_sum) / $signed({16'h0000, st_q.samples});
    avg_now = 18'(avg_full);
    avg_diff = avg_now - 18'(signed'(st_q.avg_temp));
    // departure beyond plus or minus one degree
    avg_hit = (st_q.samples != 32'h0000_0000) &&
      ((avg_diff > perm_fail_pkg::AVG_TEMP_STEP) ||
       (avg_diff < -perm_fail_pkg::AVG_TEMP_STEP));
  end

  // nothing is committed until tracking is enabled
  assign commit = i_tracking_enable_flag &&
    ((|step_hit) || (|persist_hit) || avg_hit);

  assign out_en_bits = st_q.out_en & perm_fail_pkg::OUT_EN_MASK;
  // any enabled flag trips the fuse
  assign trip = |(st_q.flags & out_en_bits);

  always_comb begin
    st_d = st_q;
    st_d.nv_write = 1'b0;
    st_d.display_button_n_start = 1'b0;

    // Register writes; flags are read-only
    if (i_reg.wr) begin
      unique case (i_reg.addr)
        perm_fail_pkg::REG_NONREM_CFG:
          st_d.nonrem_cfg = i_reg.wdata & perm_fail_pkg::NONREM_MASK;
        perm_fail_pkg::REG_FAIL_OUT_EN:
          st_d.out_en = i_reg.wdata & perm_fail_pkg::OUT_EN_MASK;
        perm_fail_pkg::REG_OP_CFG:
          st_d.op_cfg = i_reg.wdata & perm_fail_pkg::OP_CFG_MASK;
        default: ;
      endcase
    end

    // failure causes are sticky until reset
    st_d.flags = st_q.flags | (i_fail_event & perm_fail_pkg::EVENT_MASK);
    // current still flows with the fuse driven
    if (st_q.fuse_latched && i_current_flowing) begin
      st_d.flags[perm_fail_pkg::FLAG_FUSE_BLOW_FAIL] = 1'b1;
    end

    st_d.fuse_latched = st_q.fuse_latched | trip;

    // timers run only while beyond, saturate at the limit
    for (int i = 0; i < NCH; i++) begin
      if (!beyond[i]) begin
        st_d.timer[i] = 32'h0000_0000;
      end else if (st_q.timer[i] != PERSIST_CYCLES) begin
        st_d.timer[i] = st_q.timer[i] + 32'h0000_0001;
      end
    end

    if (i_meas.valid) begin
      st_d.temp_sum = st_q.temp_sum + 48'(signed'(i_meas.temp));
      st_d.samples = st_q.samples + 32'h0000_0001;
    end

    // one trigger commits every lifetime value together
    if (commit) begin
      for (int i = 0; i < NCH; i++) begin
        if (beyond[i]) begin
          st_d.life[i] = meas_x[i][15:0];
        end
        st_d.timer[i] = 32'h0000_0000;
      end
      st_d.avg_temp = avg_now[15:0];
      st_d.nv_write = 1'b1;
    end

    // Button hold time, measured while the button stays low
    if (i_display_button_n) begin
      st_d.hold_cnt = 32'h0000_0000;
    end else if (st_q.hold_cnt != HOLD_CYCLES) begin
      st_d.hold_cnt = st_q.hold_cnt + 32'h0000_0001;
    end

    // failure display after the charge display
    if (i_soc_display_done && (st_q.flags != 16'h0000) &&
        !st_q.op_cfg[perm_fail_pkg::OP_SERIAL_LED]) begin
      unique case ({st_q.op_cfg[perm_fail_pkg::OP_DISPLAY_BUTTON_N_HI],
                    st_q.op_cfg[perm_fail_pkg::OP_DISPLAY_BUTTON_N_LO]})
        perm_fail_pkg::DISPLAY_BUTTON_N_AUTO: st_d.display_button_n_start = 1'b1;
        perm_fail_pkg::DISPLAY_BUTTON_N_ON_HOLD:
          st_d.display_button_n_start = (st_q.hold_cnt == HOLD_CYCLES);
        default: st_d.display_button_n_start = 1'b0;
      endcase
    end

    // Read data stands in the cycle after the strobe only
    st_d.rdata = 16'h0000;
    if (i_reg.rd) begin
      if (i_reg.addr >= perm_fail_pkg::REG_LIFE_BASE &&
          i_reg.addr < perm_fail_pkg::REG_AVG_TEMP) begin
        st_d.rdata = st_q.life[4'(i_reg.addr -
          perm_fail_pkg::REG_LIFE_BASE)];
      end else begin
        unique case (i_reg.addr)
          perm_fail_pkg::REG_NONREM_CFG: st_d.rdata = st_q.nonrem_cfg;
          perm_fail_pkg::REG_FAIL_FLAGS: st_d.rdata = st_q.flags;
          perm_fail_pkg::REG_FAIL_OUT_EN: st_d.rdata = st_q.out_en;
          perm_fail_pkg::REG_OP_CFG: st_d.rdata = st_q.op_cfg;
          perm_fail_pkg::REG_STATUS:
            st_d.rdata = {14'h0000, i_tracking_enable_flag,
                          st_q.fuse_latched};
          perm_fail_pkg::REG_AVG_TEMP: st_d.rdata = st_q.avg_temp;
          perm_fail_pkg::REG_SAMPLES_LO: st_d.rdata = st_q.samples[15:0];
          perm_fail_pkg::REG_SAMPLES_HI: st_d.rdata = st_q.samples[31:16];
          default: st_d.rdata = 16'h0000;
        endcase
      end
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      st_q <= '0;
      st_q.life <= perm_fail_pkg::LIFE_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  assign o_rdata = st_q.rdata;
  assign o_nv_write = st_q.nv_write;
  assign o_fail_display_start = st_q.display_button_n_start;
  assign o_fuse_n = !st_q.fuse_latched;
  assign o_fuse = st_q.fuse_latched;
  // alternative recovery only in fixed pack mode
  assign o_recovery_select =
    st_q.op_cfg[perm_fail_pkg::OP_FIXED_PACK] ? st_q.nonrem_cfg : 16'h0000;

  a_fuse_trip: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    trip |=> (!o_fuse_n && o_fuse))
    else $error("enabled failure did not latch fuse");

  a_fuse_hold: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !o_fuse_n |=> !o_fuse_n [*8])
    else $error("fuse latch released");

  a_fbf_no_trip: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_fuse_n && ((st_q.flags & 16'h7FFF & st_q.out_en) == 16'h0000))
    |=> o_fuse_n)
    else $error("fuse tripped without enabled cause");

  a_fbf_flag: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (!o_fuse_n && i_current_flowing) |=> st_q.flags[15])
    else $error("fuse blow fail not flagged");

  a_event_sticky: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_fail_event[0] |=> st_q.flags[0] [*4])
    else $error("external failure flag not held");

  a_serial_blank: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    o_fail_display_start |-> !$past(st_q.op_cfg[2]))
    else $error("display started in serial mode");

  a_no_track_write: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !i_tracking_enable_flag |=> !o_nv_write)
    else $error("lifetime write before tracking");

  a_temp_step: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_tracking_enable_flag &&
     $signed(meas_x[0]) - $signed(life_x[0]) > 18'sh0000A)
    |=> (o_nv_write && st_q.life[0] == $past(i_meas.temp)))
    else $error("max temperature step not committed");

  a_timer_restart: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !beyond[2] |=> st_q.timer[2] == 32'h0000_0000)
    else $error("persistence timer not restarted");

  a_recov_gate: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (o_recovery_select != 16'h0000) |-> st_q.op_cfg[3])
    else $error("recovery selected in removable mode");

  a_fuse_pair: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    o_fuse_n != o_fuse)
    else $error("fuse outputs not complementary");

  a_flags_sticky: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (st_q.flags != 16'h0000) |=>
      ((st_q.flags & $past(st_q.flags)) == $past(st_q.flags)))
    else $error("failure flag cleared");

  a_low_flag_set: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_fail_event[7] |=> st_q.flags[7])
    else $error("flash fault flag not set");

  a_high_flag_set: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_fail_event[12] |=> st_q.flags[12])
    else $error("open thermistor flag not set");

  a_unused_flags: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    st_q.flags[14:13] == 2'h0)
    else $error("undefined flag position set");

  a_out_en_mask: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (st_q.out_en & ~perm_fail_pkg::OUT_EN_MASK) == 16'h0000)
    else $error("enable without matching flag");

  a_nonrem_mask: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (st_q.nonrem_cfg & ~perm_fail_pkg::NONREM_MASK) == 16'h0000)
    else $error("undefined recovery bit held");

  a_display_button_n_auto: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_soc_display_done && (st_q.flags != 16'h0000) &&
     (st_q.op_cfg[2:0] == 3'h3)) |=> o_fail_display_start)
    else $error("automatic failure display missing");

  a_display_button_n_off: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    !st_q.op_cfg[perm_fail_pkg::OP_DISPLAY_BUTTON_N_LO] |=> !o_fail_display_start)
    else $error("failure display in disabled mode");

  a_commit_write: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    commit |=> o_nv_write)
    else $error("lifetime set not written");

  a_cell_step: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_tracking_enable_flag && step_hit[2])
    |=> (o_nv_write && st_q.life[2] == $past(i_meas.cell_max)))
    else $error("max cell step not committed");

  a_pack_persist: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_tracking_enable_flag && persist_hit[4])
    |=> (st_q.life[4] == $past(i_meas.pack)))
    else $error("max pack persistence not committed");

  a_avg_commit: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    (i_tracking_enable_flag && avg_hit)
    |=> (st_q.avg_temp == $past(avg_now[15:0])))
    else $error("average temperature not stored");

  a_sample_count: assert property (
    @(posedge i_clk) disable iff (!i_reset_n)
    i_meas.valid |=> (st_q.samples == $past(st_q.samples) + 32'h0000_0001))
    else $error("temperature sample not counted");

endmodule

// ---- design/perm_fail_pkg.sv ----
// Constants, layouts and carrier types for the failure and lifetime block
package perm_fail_pkg;

  // Clock and timing
  localparam logic [31:0] CLK_HZ = 32'h0262_5A00;
  localparam logic [31:0] LIFETIME_PERSIST_S = 32'h0000_003C;
  localparam logic [63:0] PERSIST_CYCLES_CALC =
    64'(LIFETIME_PERSIST_S) * 64'(CLK_HZ);
  localparam logic [31:0] BUTTON_HOLD_TIME_MS = 32'h0000_0001;
  localparam logic [63:0] HOLD_CYCLES_CALC =
    (64'(BUTTON_HOLD_TIME_MS) * 64'(CLK_HZ)) / 64'h0000_0000_0000_03E8;

  // Register indices on the plain register port
  localparam int ADDR_W = 5;
  localparam logic [4:0] REG_NONREM_CFG = 5'h00;
  localparam logic [4:0] REG_FAIL_FLAGS = 5'h01;
  localparam logic [4:0] REG_FAIL_OUT_EN = 5'h02;
  localparam logic [4:0] REG_OP_CFG = 5'h03;
  localparam logic [4:0] REG_STATUS = 5'h04;
  localparam logic [4:0] REG_LIFE_BASE = 5'h08;
  localparam logic [4:0] REG_AVG_TEMP = 5'h12;
  localparam logic [4:0] REG_SAMPLES_LO = 5'h13;
  localparam logic [4:0] REG_SAMPLES_HI = 5'h14;

  // Writable and defined bits
  localparam logic [15:0] NONREM_MASK = 16'h3C07;
  localparam logic [15:0] OUT_EN_MASK = 16'h0FFF;
  localparam logic [15:0] EVENT_MASK = 16'h1FFF;
  localparam logic [15:0] OP_CFG_MASK = 16'h000F;

  // Flag positions
  localparam int FLAG_FUSE_BLOW_FAIL = 15;

  // Operating configuration fields
  localparam int OP_DISPLAY_BUTTON_N_LO = 0;
  localparam int OP_DISPLAY_BUTTON_N_HI = 1;
  localparam int OP_SERIAL_LED = 2;
  localparam int OP_FIXED_PACK = 3;
  localparam logic [1:0] DISPLAY_BUTTON_N_ON_HOLD = 2'h1;
  localparam logic [1:0] DISPLAY_BUTTON_N_AUTO = 2'h3;

  // Lifetime channels: 0 max temp, 1 min temp, 2 max cell, 3 min cell,
  // 4 max pack, 5 min pack, 6 chg current, 7 dsg current,
  // 8 chg power, 9 dsg power
  localparam int NCH = 10;
  localparam logic [NCH-1:0] CH_IS_MIN = 10'h02A;
  localparam logic [NCH-1:0] CH_SIGNED = 10'h003;
  localparam logic [NCH-1:0][15:0] LIFE_RESET = {
    16'h2710, 16'h0000, 16'h0000, 16'h0000, 16'h4E20,
    16'h0000, 16'h2710, 16'h0000, 16'h0578, 16'h0000};
  // Steps: 1.0 C (0.1 C units), 25 mV, 100 mV, 100 mA, 1000 mW (10 mW)
  localparam logic [NCH-1:0][15:0] LIFE_STEP = {
    16'h0064, 16'h0064, 16'h0064, 16'h0064, 16'h0064,
    16'h0064, 16'h0019, 16'h0019, 16'h000A, 16'h000A};
  localparam logic signed [17:0] AVG_TEMP_STEP = 18'sh0000A;

  typedef struct packed {
    logic valid;
    logic [15:0] temp;
    logic [15:0] cell_max;
    logic [15:0] cell_min;
    logic [15:0] pack;
    logic [15:0] avg_current;
    logic [15:0] avg_power;
  } meas_type;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } reg_req_type;

  typedef struct packed {
    logic [15:0] nonrem_cfg;
    logic [15:0] flags;
    logic [15:0] out_en;
    logic [15:0] op_cfg;
    logic fuse_latched;
    logic [NCH-1:0][15:0] life;
    logic [NCH-1:0][31:0] timer;
    logic [15:0] avg_temp;
    logic [47:0] temp_sum;
    logic [31:0] samples;
    logic [31:0] hold_cnt;
    logic nv_write;
    logic display_button_n_start;
    logic [15:0] rdata;
  } state_type;

endpackage

// ---- verification/fuse_led_model.sv ----
// Behavioural fuse circuit and failure display on the far side
`timescale 1ns/100ps
module fuse_led_model (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_fuse_n,
  input wire logic i_fuse,
  input wire logic i_blow_fails,
  input wire logic i_display_start,
  output logic o_current_flowing,
  output logic [7:0] o_starts
);
  logic blown_q;
  // A good fuse opens at once; a faulty one never stops the current
  assign o_current_flowing = ~blown_q &
    (i_fuse_n | ~i_fuse | i_blow_fails);
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      blown_q <= 1'b0;
      o_starts <= 8'h00;
    end else begin
      if (!i_fuse_n && i_fuse && !i_blow_fails) blown_q <= 1'b1;
      if (i_display_start) o_starts <= o_starts + 8'h01;
    end
  end
endmodule

// ---- verification/perm_fail_and_lifetime_log_tb.sv ----
// Self-checking bench for the failure and lifetime block
`timescale 1ns/100ps
module perm_fail_and_lifetime_log_tb;
  // Short counts keep the persistence and hold waits brief
  localparam logic [31:0] PC = 32'h0000_0014;
  localparam logic [31:0] HC = 32'h0000_0005;
  logic clk, rst_n, trk, btn_n, soc, fails, cur, start, fuse_n, fuse, nv;
  perm_fail_pkg::reg_req_type req;
  perm_fail_pkg::meas_type meas;
  logic [15:0] rdata, ev, rec;
  logic [7:0] starts;
  int n_errors, total_checks, c;

  perm_fail_and_lifetime_log #(.PERSIST_CYCLES(PC), .HOLD_CYCLES(HC))
    perm_fail_and_lifetime_log_i (.i_clk(clk), .i_reset_n(rst_n),
    .i_reg(req), .o_rdata(rdata), .i_fail_event(ev),
    .i_current_flowing(cur), .i_meas(meas), .i_tracking_enable_flag(trk),
    .i_display_button_n(btn_n), .i_soc_display_done(soc),
    .o_fail_display_start(start), .o_fuse_n(fuse_n), .o_fuse(fuse),
    .o_recovery_select(rec), .o_nv_write(nv));

  fuse_led_model fuse_led_model_i (.i_clk(clk), .i_reset_n(rst_n),
    .i_fuse_n(fuse_n), .i_fuse(fuse), .i_blow_fails(fails),
    .i_display_start(start), .o_current_flowing(cur), .o_starts(starts));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge clk);
    req <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    req.wr <= 1'b0;
  endtask

  task automatic chk_reg(input logic [4:0] a, input logic [15:0] e,
                         input string nm);
    @(posedge clk);
    req <= '{a, 16'h0000, 1'b0, 1'b1};
    @(posedge clk);
    req.rd <= 1'b0;
    #1 chk(nm, rdata, e);
  endtask

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic pulse(input logic [15:0] b);
    @(posedge clk);
    ev <= b;
    @(posedge clk);
    ev <= 16'h0000;
  endtask

  // Cycles until the first commit pulse, or lim+1 if none comes
  task automatic nv_first(input int lim);
    for (c = 1; c <= lim; c++) begin
      @(posedge clk);
      #1;
      if (nv === 1'b1) break;
    end
  endtask

  task automatic soc_pulse(input logic e, input string nm);
    logic [7:0] s0;
    s0 = starts;
    @(posedge clk);
    soc <= 1'b1;
    @(posedge clk);
    soc <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(nm, starts - s0, {7'h00, e});
  endtask

  task automatic t_reset();
    #1 chk("reset_outs", {fuse_n, fuse, nv, start, rec}, 20'h80000);
    chk_reg(5'h1F, 16'h0000, "unmapped");
    for (int i = 0; i < 10; i++) begin
      chk_reg(perm_fail_pkg::REG_LIFE_BASE + 5'(i),
              perm_fail_pkg::LIFE_RESET[i], "life_reset");
    end
    $display("reset test done");
  endtask

  task automatic t_regs();
    wr(perm_fail_pkg::REG_NONREM_CFG, 16'hFFFF);
    chk_reg(perm_fail_pkg::REG_NONREM_CFG, 16'h3C07, "nonrem");
    wr(perm_fail_pkg::REG_OP_CFG, 16'h0008);
    #1 chk("recov_on", rec, 16'h3C07);
    wr(perm_fail_pkg::REG_OP_CFG, 16'h0000);
    #1 chk("recov_off", rec, 16'h0000);
    wr(perm_fail_pkg::REG_FAIL_OUT_EN, 16'hFFFF);
    chk_reg(perm_fail_pkg::REG_FAIL_OUT_EN, 16'h0FFF, "out_en");
    wr(perm_fail_pkg::REG_FAIL_FLAGS, 16'hFFFF);
    chk_reg(perm_fail_pkg::REG_FAIL_FLAGS, 16'h0000, "flags_ro");
    wr(5'h1F, 16'hFFFF);
    chk_reg(5'h1F, 16'h0000, "unmapped_wr");
    $display("register test done");
  endtask

  task automatic t_fuse();
    for (int b = 0; b < 12; b++) begin
      do_reset();
      wr(perm_fail_pkg::REG_FAIL_OUT_EN, 16'(1 << b));
      // Every other cause, the open thermistor among them, is pulsed and must not trip the fuse
      pulse(16'hFFFF & ~16'(1 << b));
      repeat (2) @(posedge clk);
      #1 chk("fuse_held", fuse_n, 1'b1);
      pulse(16'(1 << b));
      @(posedge clk);
      #1 chk("fuse_trip", {fuse_n, fuse}, 2'b01);
      chk_reg(perm_fail_pkg::REG_FAIL_FLAGS, 16'h1FFF, "flags");
    end
    wr(perm_fail_pkg::REG_FAIL_OUT_EN, 16'h0000);
    repeat (3) @(posedge clk);
    #1 chk("fuse_latch", {fuse_n, fuse}, 2'b01);
    chk_reg(perm_fail_pkg::REG_STATUS, 16'h0001, "status");
    do_reset();
    fails <= 1'b1;
    wr(perm_fail_pkg::REG_FAIL_OUT_EN, 16'h0001);
    pulse(16'h0001);
    repeat (3) @(posedge clk);
    chk_reg(perm_fail_pkg::REG_FAIL_FLAGS, 16'h8001, "fbf");
    @(posedge clk);
    fails <= 1'b0;
    $display("fuse test done");
  endtask

  task automatic t_display_button_n();
    for (int m = 0; m < 4; m++) begin
      wr(perm_fail_pkg::REG_OP_CFG, 16'(m));
      soc_pulse(m == 3, "display_button_n_mode");
    end
    wr(perm_fail_pkg::REG_OP_CFG, 16'h0001);
    btn_n <= 1'b0;
    repeat (HC + 2) @(posedge clk);
    soc_pulse(1'b1, "display_button_n_hold");
    wr(perm_fail_pkg::REG_OP_CFG, 16'h0007);
    soc_pulse(1'b0, "display_button_n_serial");
    @(posedge clk);
    btn_n <= 1'b1;
    $display("display test done");
  endtask

  task automatic t_life();
    do_reset();
    meas <= '{1'b0, 16'h00FA, 16'h0E74, 16'h0E10, 16'h2AF8, 16'h0, 16'h0};
    nv_first(PC + 10);
    chk("nv_blocked", c, PC + 11);
    @(posedge clk);
    trk <= 1'b1;
    nv_first(3);
    chk("nv_step", c, 1);
    chk_reg(5'h08, 16'h00FA, "max_temp");
    chk_reg(5'h09, 16'h00FA, "min_temp");
    chk_reg(5'h0A, 16'h0E74, "max_cell");
    chk_reg(5'h0B, 16'h0E10, "min_cell");
    chk_reg(5'h0C, 16'h2AF8, "max_pack");
    chk_reg(5'h0D, 16'h2AF8, "min_pack");
    // A rise of exactly one step waits for persistence
    @(posedge clk);
    meas.temp <= 16'h0104;
    nv_first(PC + 5);
    chk("persist", (c > PC) && (c <= PC + 3), 1);
    @(posedge clk);
    meas.temp <= 16'h010E;
    repeat (10) @(posedge clk);
    meas.temp <= 16'h0104;
    repeat (2) @(posedge clk);
    meas.temp <= 16'h010E;
    nv_first(PC + 5);
    chk("restart", (c > PC) && (c <= PC + 3), 1);
    @(posedge clk);
    meas.avg_current <= 16'h0065;
    nv_first(3);
    chk("chg_cur_nv", c, 1);
    chk_reg(5'h0E, 16'h0065, "chg_cur");
    @(posedge clk);
    meas.avg_current <= 16'hFF9B;
    nv_first(3);
    chk("dsg_cur_nv", c, 1);
    chk_reg(5'h0F, 16'h0065, "dsg_cur");
    @(posedge clk);
    meas.avg_power <= 16'h0065;
    nv_first(3);
    chk("chg_pwr_nv", c, 1);
    chk_reg(5'h10, 16'h0065, "chg_pwr");
    @(posedge clk);
    meas.valid <= 1'b1;
    repeat (3) @(posedge clk);
    meas.valid <= 1'b0;
    repeat (3) @(posedge clk);
    chk_reg(perm_fail_pkg::REG_AVG_TEMP, 16'h010E, "avg_temp");
    chk_reg(perm_fail_pkg::REG_SAMPLES_LO, 16'h0003, "samples");
    $display("lifetime test done");
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    req = '0;
    ev = 16'h0000;
    meas = '0;
    trk = 1'b0;
    btn_n = 1'b1;
    soc = 1'b0;
    fails = 1'b0;
    n_errors = 0;
    total_checks = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_regs();
    t_fuse();
    t_display_button_n();
    t_life();
    complete_run();
  end
endmodule
